// ---- core/fperr_pkg.sv ----
// Package: register map, field layouts and reset values of the error reporting block
package fperr_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFF     = 8'h00;
    localparam logic [7:0] STATUS_OFF   = 8'h04;
    localparam logic [7:0] EXCMASK_OFF  = 8'h08;
    localparam logic [7:0] FLTADDR_OFF  = 8'h0c;
    localparam logic [7:0] IRQSTAT_OFF  = 8'h10;
    localparam logic [7:0] IRQCLR_OFF   = 8'h14;
    localparam logic [7:0] IRQEN_OFF    = 8'h18;
    localparam logic [7:0] FLTCLR_OFF   = 8'h1c;

    // Field positions
    localparam int NUMERIC_ERROR_SELECT_BIT = 5;
    localparam int ERROR_SUMMARY_FLAG_BIT   = 7;
    localparam int DEFER_BIT                = 0;
    localparam int NEXC                     = 6;

    // Reset values
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [5:0]  EXCMASK_RST = 6'h3f;
    localparam logic [2:0]  IRQEN_RST   = 3'h0;

    // Interrupt status bit positions
    localparam int IRQ_ERR   = 0;
    localparam int IRQ_STALL = 1;
    localparam int IRQ_IGN   = 2;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Instruction class presented by the pipeline
    typedef struct packed {
        logic        valid;
        logic        waiting;
        logic [31:0] addr;
    } fperr_instr_t;

    // Exception report from the arithmetic unit
    typedef struct packed {
        logic        valid;
        logic [5:0]  flags;
        logic [31:0] addr;
    } fperr_exc_t;

    // Bus handshake state
    typedef enum logic [2:0] {
        BUS_IDLE = 3'h1,
        BUS_RESP = 3'h2,
        BUS_HOLD = 3'h4
    } fperr_bus_st_t;

endpackage

// ---- core/fperr_lat.sv ----
`timescale 1ns/1ps
// Small holding register for the faulting instruction address
module fperr_lat #(
    parameter int W = 32
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_we,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    // Registered storage, cleared by reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_q <= '0;
        end else if (i_we) begin
            o_q <= i_d;
        end
    end
endmodule

// ---- core/fperr_top.sv ----
`timescale 1ns/1ps
// Floating-point error pin reporting path with AXI4-Lite registers
// Behaviour
// - Select bit clear selects pin error signalling
// - Unmasked exception sets flag and summary flag
// - Error pin asserts, immediately or deferred, unless ignored
// - Stall before next waiting instruction while pending
// - Ignore input held discards new error conditions in pin mode
// - Keep faulting instruction address for restart
// - Non-waiting instructions skip the pending check
module fperr_top (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire fperr_pkg::fperr_exc_t i_exc,
    input  wire fperr_pkg::fperr_instr_t i_instr,
    input  wire logic                 i_ignore_numeric_error_in_n,
    output logic                      o_fp_error_out_n,
    output logic                      o_stall,
    output logic                      o_internal_trap,
    output logic                      o_irq,
    input  wire logic [7:0]           i_awaddr,
    input  wire logic                 i_awvalid,
    output logic                      o_awready,
    input  wire logic [31:0]          i_wdata,
    input  wire logic [3:0]           i_wstrb,
    input  wire logic                 i_wvalid,
    output logic                      o_wready,
    output logic [1:0]                o_bresp,
    output logic                      o_bvalid,
    input  wire logic                 i_bready,
    input  wire logic [7:0]           i_araddr,
    input  wire logic                 i_arvalid,
    output logic                      o_arready,
    output logic [31:0]               o_rdata,
    output logic [1:0]                o_rresp,
    output logic                      o_rvalid,
    input  wire logic                 i_rready
);
    logic [31:0] ctrl_q;
    logic [5:0]  excmask_q;
    logic [5:0]  flags_q;
    logic        error_summary_flag_q;
    logic        pin_pend_q;
    logic [2:0]  irq_stat_q;
    logic [2:0]  irq_set;
    logic [2:0]  irq_clr;
    logic [2:0]  irq_en_q;
    logic [31:0] flt_addr;
    logic        ign_act;
    logic        pin_mode;
    logic [5:0]  unmasked;
    logic        new_err;
    logic        chk_wait;
    logic        wr_go;
    logic        clr_flags;
    logic [31:0] wval;
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  aw_q;
    logic [31:0] w_q;
    logic [3:0]  ws_q;

    // Mode and input decode
    assign pin_mode = ~ctrl_q[fperr_pkg::NUMERIC_ERROR_SELECT_BIT];
    assign ign_act  = ~i_ignore_numeric_error_in_n;
    assign unmasked = i_exc.flags & ~excmask_q;
    // Errors arriving while ignore is held are discarded in pin mode
    assign new_err  = i_exc.valid && (|unmasked) && !(pin_mode && ign_act);
    // Only waiting instructions look at pending state
    assign chk_wait = i_instr.valid && i_instr.waiting;

    // Write channel capture: address and data may arrive in either order
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_q      <= 8'h00;
            w_q       <= 32'h0000_0000;
            ws_q      <= 4'h0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_have_q <= 1'b1;
                aw_q      <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_have_q <= 1'b1;
                w_q      <= i_wdata;
                ws_q     <= i_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
            end
        end
    end

    assign wr_go = aw_have_q && w_have_q && !o_bvalid;
    // Byte-lane merge against the control register
    always_comb begin
        wval = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            wval[b*8 +: 8] = ws_q[b] ? w_q[b*8 +: 8] : 8'h00;
        end
    end
    assign clr_flags = wr_go && (aw_q == fperr_pkg::FLTCLR_OFF) && ws_q[0] && w_q[0];

    // Ready and write response
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= fperr_pkg::RESP_OKAY;
        end else begin
            o_awready <= !aw_have_q && !(i_awvalid && o_awready);
            o_wready  <= !w_have_q && !(i_wvalid && o_wready);
            if (wr_go) begin
                o_bvalid <= 1'b1;
                case (aw_q)
                    fperr_pkg::CTRL_OFF, fperr_pkg::EXCMASK_OFF, fperr_pkg::IRQCLR_OFF,
                    fperr_pkg::IRQEN_OFF, fperr_pkg::FLTCLR_OFF: o_bresp <= fperr_pkg::RESP_OKAY;
                    default: o_bresp <= fperr_pkg::RESP_SLVERR;
                endcase
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_q    <= fperr_pkg::CTRL_RST;
            excmask_q <= fperr_pkg::EXCMASK_RST;
            irq_en_q  <= fperr_pkg::IRQEN_RST;
        end else if (wr_go) begin
            if (aw_q == fperr_pkg::CTRL_OFF) begin
                ctrl_q <= (ctrl_q & ~{{24{1'b0}}, {8{ws_q[0]}}}) | {24'h000000, wval[7:0]};
            end
            if (aw_q == fperr_pkg::EXCMASK_OFF && ws_q[0]) begin
                excmask_q <= w_q[5:0];
            end
            if (aw_q == fperr_pkg::IRQEN_OFF && ws_q[0]) begin
                irq_en_q <= w_q[2:0];
            end
        end
    end

    // Exception flags and summary; a new error beats a same-cycle clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flags_q              <= 6'h00;
            error_summary_flag_q <= 1'b0;
        end else if (new_err) begin
            flags_q              <= (clr_flags ? 6'h00 : flags_q) | unmasked;
            error_summary_flag_q <= 1'b1;
        end else if (clr_flags) begin
            flags_q              <= 6'h00;
            error_summary_flag_q <= 1'b0;
        end
    end

    // Faulting address held for the handler's restart
    fperr_lat #(.W(32)) u_fltaddr (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_we  (new_err),
        .i_d   (i_exc.addr),
        .o_q   (flt_addr)
    );

    // Deferred pin: armed by the error, asserted at the next waiting instruction
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pin_pend_q <= 1'b0;
        end else if (clr_flags && !new_err) begin
            pin_pend_q <= 1'b0;
        end else if (new_err && ctrl_q[fperr_pkg::DEFER_BIT]) begin
            pin_pend_q <= 1'b1;
        end
    end

    // Error pin, active low; held until software clears the flags
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_fp_error_out_n <= 1'b1;
        end else if (!pin_mode || (clr_flags && !new_err)) begin
            o_fp_error_out_n <= 1'b1;
        end else if (new_err && !ctrl_q[fperr_pkg::DEFER_BIT] && !ign_act) begin
            o_fp_error_out_n <= 1'b0;
        end else if (pin_pend_q && chk_wait && !ign_act) begin
            o_fp_error_out_n <= 1'b0;
        end
    end

    // Freeze before a waiting instruction while an error is pending
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_stall         <= 1'b0;
            o_internal_trap <= 1'b0;
        end else begin
            o_stall         <= error_summary_flag_q && !clr_flags && (chk_wait || o_stall);
            o_internal_trap <= error_summary_flag_q && chk_wait && !pin_mode;
        end
    end

    // Per-bit event set and write-one clear, clear needs byte lane 0
    assign irq_set[fperr_pkg::IRQ_ERR]   = new_err;
    assign irq_set[fperr_pkg::IRQ_STALL] = error_summary_flag_q && chk_wait;
    assign irq_set[fperr_pkg::IRQ_IGN]   = i_exc.valid && (|unmasked) && ign_act;
    assign irq_clr = (wr_go && aw_q == fperr_pkg::IRQCLR_OFF && ws_q[0]) ? w_q[2:0] : 3'h0;
    // Sticky interrupt status, one flop per bit; set wins over clear
    for (genvar g = 0; g < 3; g++) begin : g_irq_stat
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                irq_stat_q[g] <= 1'b0;
            end else begin
                irq_stat_q[g] <= irq_set[g] || (irq_stat_q[g] && !irq_clr[g]);
            end
        end
    end

    // Level interrupt output
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_stat_q & irq_en_q);
        end
    end

    // Read channel: one read at a time, answer one cycle after address
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= fperr_pkg::RESP_OKAY;
        end else if (o_rvalid) begin
            if (i_rready) begin
                o_rvalid <= 1'b0;
            end
            o_arready <= 1'b0;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rresp   <= fperr_pkg::RESP_OKAY;
            case (i_araddr)
                fperr_pkg::CTRL_OFF:    o_rdata <= ctrl_q;
                fperr_pkg::STATUS_OFF:  o_rdata <= {24'h0, error_summary_flag_q, 1'b0, flags_q};
                fperr_pkg::EXCMASK_OFF: o_rdata <= {26'h0000000, excmask_q};
                fperr_pkg::FLTADDR_OFF: o_rdata <= flt_addr;
                fperr_pkg::IRQSTAT_OFF: o_rdata <= {29'h00000000, irq_stat_q};
                fperr_pkg::IRQEN_OFF:   o_rdata <= {29'h00000000, irq_en_q};
                fperr_pkg::IRQCLR_OFF, fperr_pkg::FLTCLR_OFF: o_rdata <= 32'h0000_0000;
                default: begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= fperr_pkg::RESP_SLVERR;
                end
            endcase
        end else begin
            o_arready <= 1'b1;
        end
    end

    // Pin falls only with an error recorded
    AST_PIN_NEEDS_SUMMARY: assert property (@(posedge i_clk) disable iff (i_rst)
        !o_fp_error_out_n |-> error_summary_flag_q) else $error("error pin low without summary");
    // Immediate mode asserts the pin one cycle after the error
    AST_PIN_IMMEDIATE: assert property (@(posedge i_clk) disable iff (i_rst)
        new_err && pin_mode && !ign_act && !ctrl_q[fperr_pkg::DEFER_BIT] && !clr_flags
        |=> !o_fp_error_out_n) else $error("error pin not asserted");
    // Ignored errors leave flags untouched
    AST_IGNORE_HOLDS: assert property (@(posedge i_clk) disable iff (i_rst)
        pin_mode && ign_act && !clr_flags |=> $stable(flags_q)) else $error("ignored flag set");
    // Summary follows a detected error
    AST_SUMMARY_SET: assert property (@(posedge i_clk) disable iff (i_rst)
        new_err |=> error_summary_flag_q && ((flags_q & $past(unmasked)) == $past(unmasked)))
        else $error("summary or flag missing");
    // Stall follows a waiting instruction with pending error
    AST_STALL: assert property (@(posedge i_clk) disable iff (i_rst)
        error_summary_flag_q && chk_wait && !clr_flags |=> o_stall) else $error("missing stall");
    // Non-waiting instructions alone never start a stall
    AST_NOWAIT: assert property (@(posedge i_clk) disable iff (i_rst)
        !o_stall && !chk_wait |=> !o_stall) else $error("stall without waiting instruction");
    // Clearing releases pin and stall
    AST_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst)
        clr_flags && !new_err |=> o_fp_error_out_n && !o_stall) else $error("no release");
    // Address captured on error
    AST_ADDR: assert property (@(posedge i_clk) disable iff (i_rst)
        new_err |=> flt_addr == $past(i_exc.addr)) else $error("fault address not kept");
    // Native mode never drives the pin
    AST_NATIVE: assert property (@(posedge i_clk) disable iff (i_rst)
        !pin_mode |=> o_fp_error_out_n) else $error("pin driven in native mode");
endmodule

// ---- sim/fperr_pic_model.sv ----
`timescale 1ns/1ps
// Behavioural interrupt controller and glue behind the error pin
module fperr_irq_ctrl_model #(
    parameter logic [7:0] VEC = 8'h75
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_fp_error_out_n,
    output logic            o_maskable_irq_in,
    output logic [7:0]      o_vector
);
    logic line_thirteen;

    // Glue inverts the active-low pin onto request line thirteen
    assign line_thirteen = ~i_fp_error_out_n;

    // Level request; one cycle of latency like a registered controller
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_maskable_irq_in <= 1'b0;
        end else begin
            o_maskable_irq_in <= line_thirteen;
        end
    end

    assign o_vector = VEC;
endmodule

// ---- sim/fperr_top_test.sv ----
`timescale 1ns/1ps
// Self-checking bench for the error pin reporting block
module fperr_top_test;
    logic clk, rst, ign_n, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    fperr_pkg::fperr_exc_t   exc;
    fperr_pkg::fperr_instr_t instr;
    logic pin_n, stall, trap, irq, awready, wready, bvalid, arready, rvalid, ctrl_irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, fa;
    logic [7:0]  vec;
    logic [5:0]  fl;
    logic [33:0] rd_q[$];
    logic [33:0] note;
    int n_errors, checks_done, n_trap, seed;

    fperr_top uut (.i_clk(clk), .i_rst(rst), .i_exc(exc), .i_instr(instr),
        .i_ignore_numeric_error_in_n(ign_n), .o_fp_error_out_n(pin_n), .o_stall(stall),
        .o_internal_trap(trap), .o_irq(irq), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
        .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
    fperr_irq_ctrl_model irq_ctrl (.i_clk(clk), .i_rst(rst), .i_fp_error_out_n(pin_n),
        .o_maskable_irq_in(ctrl_irq), .o_vector(vec));

    // Free-running 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %0b seen %0b", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [33:0] e, input logic [33:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Level check away from the edge, then back onto the edge
    task automatic lvl(input string nm, input logic e, ref logic g);
        #1;
        chk_bit(nm, e, g);
        @(posedge clk);
    endtask

    // Write: both channels offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk); while (bvalid !== 1'b1);
        chk_word("bresp", {32'h0, er}, {32'h0, bresp});
        bready <= 1'b0;
    endtask

    // Read: expected answer noted, monitor compares it
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        rd_q.push_back({er, ed});
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask

    task automatic fire_exc(input logic [5:0] f, input logic [31:0] a);
        exc <= {1'b1, f, a};
        @(posedge clk);
        exc <= '0;
        @(posedge clk);
    endtask

    task automatic issue(input logic w);
        instr <= {1'b1, w, 32'h0000_1000};
        @(posedge clk);
        instr <= '0;
        @(posedge clk);
    endtask

    // Read answers taken oldest first
    always @(posedge clk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            note = (rd_q.size() > 0) ? rd_q.pop_front() : 34'h3_ffff_ffff;
            chk_word("read", note, {rresp, rdata});
        end
    end

    // Internal trap pulses counted
    always @(posedge clk) begin
        if (trap === 1'b1) n_trap++;
    end

    // Hang guard sized well above the sequence length
    initial begin
        #(50 * 4000);
        n_errors++;
        stop_test();
    end

    initial begin
        seed = 32'h3ea8cf9c;
        n_errors = 0; checks_done = 0; n_trap = 0;
        rst = 1'b1; ign_n = 1'b1; exc = '0; instr = '0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        lvl("pin_n", 1'b1, pin_n);
        axi_rd(fperr_pkg::CTRL_OFF, 32'h0, fperr_pkg::RESP_OKAY);
        axi_rd(fperr_pkg::EXCMASK_OFF, 32'h3f, fperr_pkg::RESP_OKAY);
        axi_rd(8'h20, 32'h0, fperr_pkg::RESP_SLVERR);
        axi_wr(fperr_pkg::STATUS_OFF, 32'hff, fperr_pkg::RESP_SLVERR);
        axi_wr(fperr_pkg::EXCMASK_OFF, 32'h0, fperr_pkg::RESP_OKAY);
        axi_wr(fperr_pkg::IRQEN_OFF, 32'h1, fperr_pkg::RESP_OKAY);
        // Immediate pin mode with random flags and address
        fl = 6'($random(seed));
        fl = fl | 6'h01;
        fa = $random(seed);
        fire_exc(fl, fa);
        lvl("pin_n", 1'b0, pin_n);
        axi_rd(fperr_pkg::STATUS_OFF, {24'h0, 2'h2, fl}, fperr_pkg::RESP_OKAY);
        axi_rd(fperr_pkg::FLTADDR_OFF, fa, fperr_pkg::RESP_OKAY);
        lvl("irq", 1'b1, irq);
        lvl("ctrl_irq", 1'b1, ctrl_irq);
        issue(1'b0);
        lvl("stall", 1'b0, stall);
        issue(1'b1);
        lvl("stall", 1'b1, stall);
        axi_wr(fperr_pkg::FLTCLR_OFF, 32'h1, fperr_pkg::RESP_OKAY);
        @(posedge clk);
        lvl("pin_n", 1'b1, pin_n);
        lvl("stall", 1'b0, stall);
        axi_rd(fperr_pkg::IRQSTAT_OFF, 32'h3, fperr_pkg::RESP_OKAY);
        axi_wr(fperr_pkg::IRQCLR_OFF, 32'h7, fperr_pkg::RESP_OKAY);
        repeat (2) @(posedge clk);
        lvl("irq", 1'b0, irq);
        // Ignore input active: error discarded
        ign_n <= 1'b0;
        fire_exc(6'h04, 32'h0000_2222);
        lvl("pin_n", 1'b1, pin_n);
        axi_rd(fperr_pkg::STATUS_OFF, 32'h0, fperr_pkg::RESP_OKAY);
        axi_rd(fperr_pkg::IRQSTAT_OFF, 32'h4, fperr_pkg::RESP_OKAY);
        ign_n <= 1'b1;
        axi_wr(fperr_pkg::IRQCLR_OFF, 32'h7, fperr_pkg::RESP_OKAY);
        // Deferred mode: pin waits for the next waiting instruction
        axi_wr(fperr_pkg::CTRL_OFF, 32'h1, fperr_pkg::RESP_OKAY);
        fire_exc(6'h08, 32'h0000_3333);
        lvl("pin_n", 1'b1, pin_n);
        issue(1'b1);
        lvl("pin_n", 1'b0, pin_n);
        axi_wr(fperr_pkg::FLTCLR_OFF, 32'h1, fperr_pkg::RESP_OKAY);
        // Select bit set: internal trap instead of the pin
        axi_wr(fperr_pkg::CTRL_OFF, 32'h20, fperr_pkg::RESP_OKAY);
        n_trap = 0;
        fire_exc(6'h02, 32'h0000_4444);
        issue(1'b1);
        repeat (3) @(posedge clk);
        lvl("pin_n", 1'b1, pin_n);
        chk_word("traps", 34'h1, {2'b00, n_trap});
        chk_word("vector", 34'h75, {26'h0, vec});
        stop_test();
    end
endmodule
